/* hdl/tsa_pkg.sv */
// Purpose: Shared constants for the tuner search and AFC control block
// Assumes: 10 MHz core clock
// Notes: Times are kept in their own unit; cycle counts derive from them
package tsa_pkg;
   localparam int CLK_HZ = 10000000;
   localparam int MUTE_LEAD_MS = 110;
   localparam int MUTE_HOLD_MS = 320;
   localparam int WRAP_PAUSE_MS = 210;
   localparam int DEBOUNCE_MS = 31;
   localparam int MUTE_LEAD_CYC = MUTE_LEAD_MS * (CLK_HZ / 1000);
   localparam int MUTE_HOLD_CYC = MUTE_HOLD_MS * (CLK_HZ / 1000);
   localparam int WRAP_PAUSE_CYC = WRAP_PAUSE_MS * (CLK_HZ / 1000);
   localparam int DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
   // Slow AFC rates as printed, in tenths of hertz
   localparam int SLOW_UP_DHZ = 677;
   localparam int SLOW_DN_DHZ = 84;
   localparam int SLOW_UP_CYC = (CLK_HZ * 10) / SLOW_UP_DHZ;
   localparam int SLOW_DN_CYC = (CLK_HZ * 10) / SLOW_DN_DHZ;
   localparam int IGNORE_STEPS = 15;
   localparam int RECALL_OFFSET = 8;
   localparam int TUNE_W = 13;
   localparam logic [12:0] TUNE_MAX = 13'h1FFF;
   localparam logic [12:0] TUNE_MIN = 13'h0000;
   // Band codes: one-hot drive bit index
   localparam logic [1:0] BAND_V1 = 2'h0;
   localparam logic [1:0] BAND_V3 = 2'h1;
   localparam logic [1:0] BAND_UHF = 2'h2;
   localparam logic [1:0] BAND_S = 2'h3;
   // Fast-up divides of the RC tick
   localparam int FAST_DIV_VHF = 1;
   localparam int FAST_DIV_UHF = 2;
   localparam int MED_FACTOR = 4;
   localparam logic [1:0] VAR_TWO_GROUP = 2'h0;
   localparam logic [1:0] VAR_SINGLE = 2'h1;
endpackage : tsa_pkg

/* hdl/tsa_debounce.sv */
// Purpose: Debounce one decoded key level with one-shot acceptance
// Assumes: Input already synchronised to the core clock
// Notes: Counter restarts the moment the key drops
`timescale 1ns/1ps
`default_nettype none
module tsa_debounce #(
   parameter int CYCLES = tsa_pkg::DEBOUNCE_CYC
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_key,
   output logic o_accept
);
   logic [24:0] cnt_reg;
   logic done_reg;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt_reg <= 25'h000_0000;
         done_reg <= 1'b0;
         o_accept <= 1'b0;
      end else if (i_ce) begin
         o_accept <= 1'b0;
         if (!i_key) begin
            cnt_reg <= 25'h000_0000;
            done_reg <= 1'b0;
         end else if (!done_reg) begin
            if (cnt_reg == 25'(CYCLES - 1)) begin
               done_reg <= 1'b1;
               o_accept <= 1'b1;
            end else begin
               cnt_reg <= cnt_reg + 25'h000_0001;
            end
         end
      end
   end
endmodule : tsa_debounce
`default_nettype wire

/* hdl/tsa_core.sv */
// Purpose: Search, AFC, recall offset, band drive and mute control
// Assumes: Three-level pins arrive as high/low pairs from the pad
// Notes: RC oscillator arrives as a pin sampled into a tick
`timescale 1ns/1ps
`default_nettype none
module tsa_core #(
   parameter logic [1:0] VARIANT = tsa_pkg::VAR_TWO_GROUP,
   parameter int MUTE_LEAD = tsa_pkg::MUTE_LEAD_CYC,
   parameter int MUTE_HOLD = tsa_pkg::MUTE_HOLD_CYC,
   parameter int WRAP_PAUSE = tsa_pkg::WRAP_PAUSE_CYC,
   parameter int DEBOUNCE = tsa_pkg::DEBOUNCE_CYC,
   parameter int SLOW_UP = tsa_pkg::SLOW_UP_CYC,
   parameter int SLOW_DN = tsa_pkg::SLOW_DN_CYC
) (
   input wire logic I_CORE_CLK,
   input wire logic I_RST,
   input wire logic I_CE,
   input wire logic I_AUTO_MODE,
   input wire logic I_LOCK_HI,
   input wire logic I_LOCK_LO,
   input wire logic I_KEY_HI,
   input wire logic I_KEY_LO,
   input wire logic I_RC_OSC,
   input wire logic [3:0] I_PROG_SEL,
   input wire logic I_SUPPLY_OK,
   input wire logic I_STORE_BUSY,
   input wire logic I_RECALL_VALID,
   input wire logic [12:0] I_RECALL_TUNE,
   input wire logic [1:0] I_RECALL_BAND,
   input wire logic I_BAND_STEP,
   output logic [12:0] O_TUNE,
   output logic [3:0] O_BAND_OE,
   output logic O_MUTE,
   output logic O_SEARCHING,
   output logic O_PROG_LOAD
);
   // ****************************************
   // Input synchronisers
   // ****************************************
   logic [7:0] meta_reg;
   logic [7:0] sync_reg;
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         meta_reg <= 8'h00;
         sync_reg <= 8'h00;
      end else if (I_CE) begin
         meta_reg <= {I_AUTO_MODE, I_LOCK_HI, I_LOCK_LO, I_KEY_HI,
                      I_KEY_LO, I_RC_OSC, I_SUPPLY_OK, I_BAND_STEP};
         sync_reg <= meta_reg;
      end
   end
   logic [3:0] pmeta_reg;
   logic [3:0] psync_reg;
   logic [3:0] pold_reg;
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         pmeta_reg <= 4'h0;
         psync_reg <= 4'h0;
         pold_reg <= 4'h0;
      end else if (I_CE) begin
         pmeta_reg <= I_PROG_SEL;
         psync_reg <= pmeta_reg;
         pold_reg <= psync_reg;
      end
   end
   wire auto_m = sync_reg[7];
   wire lk_hi = sync_reg[6];
   wire lk_lo = sync_reg[5];
   wire k_hi = sync_reg[4] & ~sync_reg[3];
   wire k_lo = sync_reg[3] & ~sync_reg[4];
   wire supply = sync_reg[1];
   wire prog_chg = psync_reg != pold_reg;

   // ****************************************
   // RC step tick and rate division
   // ****************************************
   logic rc_old_reg;
   logic [2:0] div_reg;
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         rc_old_reg <= 1'b0;
         div_reg <= 3'h0;
      end else if (I_CE) begin
         rc_old_reg <= sync_reg[2];
         if (sync_reg[2] & ~rc_old_reg) div_reg <= div_reg + 3'h1;
      end
   end
   wire rc_tick = sync_reg[2] & ~rc_old_reg;

   // ****************************************
   // Manual keys
   // ****************************************
   logic acc_up;
   logic acc_dn;
   tsa_debounce #(.CYCLES(DEBOUNCE)) u_db_up (
      .i_clk(I_CORE_CLK), .i_rst(I_RST), .i_ce(I_CE),
      .i_key(k_hi), .o_accept(acc_up));
   tsa_debounce #(.CYCLES(DEBOUNCE)) u_db_dn (
      .i_clk(I_CORE_CLK), .i_rst(I_RST), .i_ce(I_CE),
      .i_key(k_lo), .o_accept(acc_dn));
   // Held-key manual stepping needs the raw level after acceptance
   logic man_up_reg;
   logic man_dn_reg;
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         man_up_reg <= 1'b0;
         man_dn_reg <= 1'b0;
      end else if (I_CE) begin
         if (acc_up) man_up_reg <= 1'b1;
         else if (!k_hi) man_up_reg <= 1'b0;
         if (acc_dn) man_dn_reg <= 1'b1;
         else if (!k_lo) man_dn_reg <= 1'b0;
      end
   end

   // ****************************************
   // Search state machine
   // ****************************************
   typedef enum logic [6:0] {
      S_IDLE = 7'h01, S_LEAD = 7'h02, S_FAST = 7'h04, S_MED = 7'h08,
      S_PAUSE = 7'h10, S_CHG = 7'h20, S_AFC = 7'h40
   } tsa_state_t;
   tsa_state_t st_reg;
   logic [22:0] tmr_reg;
   logic [3:0] ign_reg;
   logic seen_lo_reg;
   logic lk_hi_old_reg;
   logic lk_lo_old_reg;
   logic grp_hi_reg;
   logic start_pend_reg;
   logic chg_pend_reg;
   logic [12:0] tune_reg;
   logic [1:0] band_reg;
   logic [20:0] slow_reg; // Slow-down period needs 21 bits at full clock
   logic was_auto_reg;

   wire start_req = (acc_up | acc_dn) & auto_m;
   wire fast_band = (band_reg == tsa_pkg::BAND_V1)
                  | (band_reg == tsa_pkg::BAND_V3);
   wire [2:0] fast_mask = fast_band ? 3'h0 : 3'h1;
   wire step_fast = rc_tick & ((div_reg & fast_mask) == 3'h0);
   wire [2:0] med_mask = fast_band ? 3'h3 : 3'h7;
   wire step_med = rc_tick & ((div_reg & med_mask) == 3'h0);
   wire lock_en = auto_m & (st_reg != S_CHG);
   wire m_to_h = lock_en & lk_hi & ~lk_hi_old_reg;
   wire m_to_l = lock_en & lk_lo & ~lk_lo_old_reg;

   function automatic logic [1:0] first_band(input logic hi_grp,
                                              input logic fast);
      if (VARIANT != tsa_pkg::VAR_TWO_GROUP) first_band = 2'h0;
      else if (hi_grp)
         first_band = fast ? tsa_pkg::BAND_V1 : tsa_pkg::BAND_S;
      else
         first_band = fast ? tsa_pkg::BAND_V3 : tsa_pkg::BAND_UHF;
   endfunction : first_band

   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         lk_hi_old_reg <= 1'b0;
         lk_lo_old_reg <= 1'b0;
      end else if (I_CE) begin
         lk_hi_old_reg <= lk_hi;
         lk_lo_old_reg <= lk_lo;
      end
   end

   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         st_reg <= S_IDLE;
         tmr_reg <= 23'h00_0000;
         ign_reg <= 4'h0;
         seen_lo_reg <= 1'b0;
         grp_hi_reg <= 1'b0;
         start_pend_reg <= 1'b0;
         chg_pend_reg <= 1'b0;
         tune_reg <= 13'h0000;
         band_reg <= tsa_pkg::BAND_V3;
         slow_reg <= 21'h0_0000;
         was_auto_reg <= 1'b0;
         O_PROG_LOAD <= 1'b0;
      end else if (I_CE) begin
         O_PROG_LOAD <= 1'b0;
         was_auto_reg <= auto_m;
         if (prog_chg) chg_pend_reg <= 1'b1;
         if (start_req) begin
            start_pend_reg <= 1'b1;
            grp_hi_reg <= acc_up;
         end
         case (st_reg)
            S_IDLE, S_AFC: begin
               if (I_STORE_BUSY) begin
                  st_reg <= st_reg;
               end else if (chg_pend_reg | prog_chg) begin
                  chg_pend_reg <= 1'b0;
                  st_reg <= S_CHG;
                  tmr_reg <= 23'h00_0000;
               end else if (start_pend_reg) begin
                  start_pend_reg <= 1'b0;
                  st_reg <= S_LEAD;
                  tmr_reg <= 23'h00_0000;
               end else if (!auto_m) begin
                  st_reg <= S_IDLE;
                  if (man_up_reg & step_fast)
                     tune_reg <= tune_reg + 13'h0001;
                  else if (man_dn_reg & step_fast)
                     tune_reg <= tune_reg - 13'h0001;
                  if (sync_reg[0] & ~was_auto_reg)
                     band_reg <= band_reg;
               end else begin
                  st_reg <= S_AFC;
                  slow_reg <= slow_reg + 21'h0_0001;
                  if (lk_lo & !lk_hi) begin
                     if (slow_reg >= 21'(SLOW_UP - 1)) begin
                        slow_reg <= 21'h0_0000;
                        tune_reg <= tune_reg + 13'h0001;
                     end
                  end else if (lk_hi & !lk_lo) begin
                     if (slow_reg >= 21'(SLOW_DN - 1)) begin
                        slow_reg <= 21'h0_0000;
                        tune_reg <= tune_reg - 13'h0001;
                     end
                  end else begin
                     slow_reg <= 21'h0_0000;
                  end
               end
            end
            S_LEAD: begin
               tmr_reg <= tmr_reg + 23'h00_0001;
               if (prog_chg) begin
                  st_reg <= S_CHG;
                  chg_pend_reg <= 1'b0;
                  tmr_reg <= 23'h00_0000;
               end else if (tmr_reg == 23'(MUTE_LEAD - 1)) begin
                  st_reg <= S_FAST;
                  // A fresh start opens its group on the fast band
                  band_reg <= first_band(grp_hi_reg, 1'b1);
                  if (VARIANT != tsa_pkg::VAR_TWO_GROUP)
                     band_reg <= band_reg;
                  tune_reg <= tsa_pkg::TUNE_MIN;
                  ign_reg <= 4'h0;
                  seen_lo_reg <= 1'b0;
               end
            end
            S_FAST, S_MED, S_PAUSE: begin
               if (prog_chg | !auto_m) begin
                  st_reg <= auto_m ? S_CHG : S_IDLE;
                  chg_pend_reg <= 1'b0;
                  tmr_reg <= 23'h00_0000;
               end else if (start_pend_reg &&
                            VARIANT == tsa_pkg::VAR_TWO_GROUP) begin
                  start_pend_reg <= 1'b0;
                  st_reg <= S_FAST;
                  band_reg <= first_band(grp_hi_reg, fast_band);
                  tune_reg <= tsa_pkg::TUNE_MIN;
                  ign_reg <= 4'h0;
                  seen_lo_reg <= 1'b0;
               end else if (st_reg == S_PAUSE) begin
                  tmr_reg <= tmr_reg + 23'h00_0001;
                  if (tmr_reg == 23'(WRAP_PAUSE - 1)) begin
                     st_reg <= S_FAST;
                     tune_reg <= tsa_pkg::TUNE_MIN;
                     ign_reg <= 4'h0;
                     seen_lo_reg <= 1'b0;
                     if (VARIANT == tsa_pkg::VAR_TWO_GROUP)
                        band_reg <= first_band(grp_hi_reg, ~fast_band);
                  end
               end else if (st_reg == S_FAST) begin
                  if (m_to_l && ign_reg == 4'(tsa_pkg::IGNORE_STEPS))
                     seen_lo_reg <= 1'b1;
                  if (m_to_h && seen_lo_reg &&
                      ign_reg == 4'(tsa_pkg::IGNORE_STEPS)) begin
                     st_reg <= S_MED;
                  end else if (step_fast) begin
                     if (ign_reg != 4'(tsa_pkg::IGNORE_STEPS))
                        ign_reg <= ign_reg + 4'h1;
                     if (tune_reg == tsa_pkg::TUNE_MAX) begin
                        st_reg <= S_PAUSE;
                        tmr_reg <= 23'h00_0000;
                     end else begin
                        tune_reg <= tune_reg + 13'h0001;
                     end
                  end
               end else begin
                  if (m_to_l) begin
                     st_reg <= S_AFC;
                     slow_reg <= 21'h0_0000;
                  end else if (step_med) begin
                     tune_reg <= tune_reg - 13'h0001;
                  end
               end
            end
            S_CHG: begin
               tmr_reg <= tmr_reg + 23'h00_0001;
               if (tmr_reg == 23'(MUTE_LEAD - 1)) begin
                  O_PROG_LOAD <= 1'b1;
               end
               if (I_RECALL_VALID && tmr_reg >= 23'(MUTE_LEAD)) begin
                  band_reg <= I_RECALL_BAND;
                  tune_reg <= auto_m
                     ? I_RECALL_TUNE - 13'(tsa_pkg::RECALL_OFFSET)
                     : I_RECALL_TUNE;
               end
               if (tmr_reg == 23'(MUTE_HOLD - 1)) begin
                  st_reg <= S_IDLE;
               end
            end
            default: st_reg <= S_IDLE;
         endcase
      end
   end

   // ****************************************
   // Mute and outputs
   // ****************************************
   logic [22:0] pwr_reg;
   logic pwr_mute_reg;
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         pwr_reg <= 23'h00_0000;
         pwr_mute_reg <= 1'b1;
      end else if (I_CE) begin
         if (!supply) begin
            pwr_reg <= 23'h00_0000;
            pwr_mute_reg <= 1'b1;
         end else if (pwr_reg == 23'(MUTE_HOLD - 1)) begin
            pwr_mute_reg <= 1'b0;
         end else begin
            pwr_reg <= pwr_reg + 23'h00_0001;
         end
      end
   end

   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_MUTE <= 1'b1;
         O_SEARCHING <= 1'b0;
         O_TUNE <= 13'h0000;
         O_BAND_OE <= 4'h0;
      end else if (I_CE) begin
         O_MUTE <= pwr_mute_reg | (st_reg == S_LEAD) | (st_reg == S_FAST)
                 | (st_reg == S_MED) | (st_reg == S_PAUSE)
                 | (st_reg == S_CHG);
         O_SEARCHING <= (st_reg == S_FAST) | (st_reg == S_MED)
                      | (st_reg == S_PAUSE);
         O_TUNE <= tune_reg;
         O_BAND_OE <= 4'h1 << band_reg;
      end
   end
endmodule : tsa_core
`default_nettype wire

/* tb/tsa_panel_model.sv */
// Purpose: Front-panel key and lock detector model for the search core
// Assumes: Level codes 0 middle, 1 high, 2 low
// Notes: RC oscillator free-runs with a step every four clocks
`timescale 1ns/1ps
`default_nettype none
module tsa_panel_model (
   input wire logic i_clk,
   input wire logic [1:0] i_lock_lvl,
   input wire logic [1:0] i_key_lvl,
   output logic o_lock_hi,
   output logic o_lock_lo,
   output logic o_key_hi,
   output logic o_key_lo,
   output logic o_rc_osc
);
   // ***************************************
   // Levels and step oscillator
   // ***************************************
   logic [1:0] rc_div_reg = 2'h0;
   logic [1:0] key_prev_reg = 2'h0;
   always_ff @(posedge i_clk) begin
      rc_div_reg <= rc_div_reg + 2'h1;
      key_prev_reg <= i_key_lvl;
   end
   assign o_rc_osc = rc_div_reg[1];
   assign o_lock_hi = (i_lock_lvl == 2'h1);
   assign o_lock_lo = (i_lock_lvl == 2'h2);
   // A swing from one side to the other passes through middle
   assign o_key_hi = (i_key_lvl == 2'h1) && (key_prev_reg != 2'h2);
   assign o_key_lo = (i_key_lvl == 2'h2) && (key_prev_reg != 2'h1);
endmodule : tsa_panel_model
`default_nettype wire

/* tb/tsa_checker.sv */
// Purpose: Port assertions for the search and AFC core
// Assumes: Lead length handed on by the bind
// Notes: Helper counters stand in for long windows
`timescale 1ns/1ps
`default_nettype none
module tsa_checker #(
   parameter int MUTE_LEAD = 20
) (
   input wire logic I_CORE_CLK,
   input wire logic I_RST,
   input wire logic I_AUTO_MODE,
   input wire logic I_LOCK_HI,
   input wire logic I_LOCK_LO,
   input wire logic I_KEY_HI,
   input wire logic I_KEY_LO,
   input wire logic I_SUPPLY_OK,
   input wire logic [12:0] O_TUNE,
   input wire logic [3:0] O_BAND_OE,
   input wire logic O_MUTE,
   input wire logic O_SEARCHING,
   input wire logic O_PROG_LOAD
);
   // ***************************************
   // Helper counters
   // ***************************************
   int mute_cnt;
   int quiet_cnt;
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST || !O_MUTE) begin
         mute_cnt <= 0;
      end else if (mute_cnt < 1000) begin
         mute_cnt <= mute_cnt + 1;
      end
   end
   // Six quiet cycles cover the input synchronisers
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST || I_KEY_HI || I_KEY_LO || O_MUTE || !I_SUPPLY_OK
            || (I_AUTO_MODE && (I_LOCK_HI || I_LOCK_LO))) begin
         quiet_cnt <= 0;
      end else if (quiet_cnt < 15) begin
         quiet_cnt <= quiet_cnt + 1;
      end
   end
   // ***************************************
   // Assertions
   // ***************************************
   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (I_RST);
   a_band_one_hot: assert property (!$past(I_RST) |-> $onehot(O_BAND_OE))
      else $error("band drive not one-hot");
   a_search_muted: assert property (O_SEARCHING |-> O_MUTE)
      else $error("search without mute");
   a_search_lead: assert property ($rose(O_SEARCHING) |-> mute_cnt >= MUTE_LEAD - 2)
      else $error("search began before mute lead");
   a_supply_mute: assert property ($fell(I_SUPPLY_OK) |-> ##[1:4] O_MUTE)
      else $error("no mute on supply loss");
   a_tune_quiet: assert property (quiet_cnt >= 6 |=> $stable(O_TUNE))
      else $error("tune moved with no command");
   a_tune_step: assert property ((!O_MUTE && $changed(O_TUNE)) |->
      (13'(O_TUNE - $past(O_TUNE)) == 13'h0001 ||
       13'($past(O_TUNE) - O_TUNE) == 13'h0001))
      else $error("tune step not one");
   a_load_lead: assert property (O_PROG_LOAD |-> O_MUTE && mute_cnt >= MUTE_LEAD - 2)
      else $error("program load before mute lead");
   a_load_pulse: assert property (O_PROG_LOAD |=> !O_PROG_LOAD)
      else $error("program load longer than one cycle");
   a_reset_idle: assert property (disable iff (1'b0) I_RST |=> O_MUTE &&
      !O_SEARCHING && O_TUNE == 13'h0000 && O_BAND_OE == 4'h0)
      else $error("reset state wrong");
   c_search: cover property ($rose(O_SEARCHING));
   c_load: cover property (O_PROG_LOAD);
   c_man_lock: cover property (quiet_cnt >= 6 && I_LOCK_LO && !I_AUTO_MODE);
endmodule : tsa_checker
bind tsa_core tsa_checker #(.MUTE_LEAD(MUTE_LEAD)) u_chk (.I_CORE_CLK,
   .I_RST, .I_AUTO_MODE, .I_LOCK_HI, .I_LOCK_LO, .I_KEY_HI, .I_KEY_LO,
   .I_SUPPLY_OK, .O_TUNE, .O_BAND_OE, .O_MUTE, .O_SEARCHING, .O_PROG_LOAD);
`default_nettype wire

/* tb/tb_tuner_search_afc_control.sv */
// Purpose: Self-checking bench for the search and AFC core
// Assumes: Shortened timing parameters, RC step every four clocks
// Notes: Three-level pins are driven through the panel model
`timescale 1ns/1ps
`default_nettype none
module tb_tuner_search_afc_control;
   // ***************************************
   // Stimulus and instances
   // ***************************************
   localparam int LEAD = 20;
   localparam int HOLD = 50;
   localparam int DEB = 8;
   localparam int SUP = 10;
   localparam int SDN = 40;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic auto_mode = 1'b0;
   logic supply_ok = 1'b1;
   logic store_busy = 1'b0;
   logic [1:0] lock_lvl = 2'h0;
   logic [1:0] key_lvl = 2'h0;
   logic [3:0] prog_sel = 4'h0;
   logic [12:0] rec_tune = 13'h0100;
   logic [1:0] rec_band = tsa_pkg::BAND_UHF;
   logic lock_hi, lock_lo, key_hi, key_lo, rc_osc, mute, srch, load;
   logic [12:0] tune;
   logic [3:0] band;
   int mismatches = 0;
   int total_checks = 0;
   int cycles = 0;
   always #50 clk = ~clk;
   tsa_panel_model u_panel (.i_clk(clk), .i_lock_lvl(lock_lvl),
      .i_key_lvl(key_lvl), .o_lock_hi(lock_hi), .o_lock_lo(lock_lo),
      .o_key_hi(key_hi), .o_key_lo(key_lo), .o_rc_osc(rc_osc));
   tsa_core #(.MUTE_LEAD(LEAD), .MUTE_HOLD(HOLD), .WRAP_PAUSE(30),
      .DEBOUNCE(DEB), .SLOW_UP(SUP), .SLOW_DN(SDN)) dut (
      .I_CORE_CLK(clk), .I_RST(rst), .I_CE(1'b1), .I_AUTO_MODE(auto_mode),
      .I_LOCK_HI(lock_hi), .I_LOCK_LO(lock_lo), .I_KEY_HI(key_hi),
      .I_KEY_LO(key_lo), .I_RC_OSC(rc_osc), .I_PROG_SEL(prog_sel),
      .I_SUPPLY_OK(supply_ok), .I_STORE_BUSY(store_busy),
      .I_RECALL_VALID(1'b1), .I_RECALL_TUNE(rec_tune),
      .I_RECALL_BAND(rec_band), .I_BAND_STEP(1'b0), .O_TUNE(tune),
      .O_BAND_OE(band), .O_MUTE(mute), .O_SEARCHING(srch),
      .O_PROG_LOAD(load));
   // ***************************************
   // Shared tasks
   // ***************************************
   task automatic chk(input string nm, input logic [12:0] exp, got);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   function automatic logic pick(input int s);
      return (s == 0) ? mute : ((s == 1) ? srch : load);
   endfunction : pick
   // Bounded wait, counting settled cycles
   task automatic wait_sig(input int s, input logic v, output int n);
      n = 0;
      while (pick(s) !== v && n < 400) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk("wait", 13'h1, 13'(n < 400));
   endtask : wait_sig
   task automatic stop_test();
      $display("Checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : stop_test
   always @(posedge clk) begin
      cycles++;
      if (cycles == 8000) begin
         mismatches++;
         stop_test();
      end
   end
   // ***************************************
   // Scenarios
   // ***************************************
   task automatic t_power();
      int n;
      cyc(9);
      #1;
      chk("rst_mute", 13'h1, 13'(mute));
      chk("rst_tune", 13'h0000, tune);
      cyc(1);
      rst <= 1'b0;
      cyc(3);
      #1;
      chk("band_init", 13'h0002, 13'(band));
      wait_sig(0, 1'b0, n);
      chk("mute_power", 13'h1, 13'(n >= HOLD - 4));
      cyc(1);
      supply_ok <= 1'b0;
      cyc(5);
      #1;
      chk("mute_supply", 13'h1, 13'(mute));
      cyc(1);
      supply_ok <= 1'b1;
      wait_sig(0, 1'b0, n);
      $display("Test power done");
   endtask : t_power
   task automatic t_manual();
      logic [12:0] t;
      cyc(1);
      lock_lvl <= 2'h2;
      cyc(10);
      #1;
      t = tune;
      cyc(40);
      #1;
      chk("man_lock", t, tune);
      cyc(1);
      key_lvl <= 2'h2;
      cyc(DEB + 40);
      key_lvl <= 2'h0;
      #1;
      chk("man_wrap", 13'h1, 13'(tune > 13'h1F00));
      cyc(6);
      key_lvl <= 2'h1;
      cyc(DEB + 80);
      key_lvl <= 2'h0;
      lock_lvl <= 2'h0;
      #1;
      chk("man_up", 13'h1, 13'(tune < 13'h0100));
      $display("Test manual done");
   endtask : t_manual
   task automatic t_prog(input logic a, input logic [12:0] tin, exp,
         input logic [1:0] b, input logic [3:0] bexp);
      int n1, n2;
      cyc(1);
      auto_mode <= a;
      rec_tune <= tin;
      rec_band <= b;
      cyc(4);
      prog_sel <= prog_sel + 4'h1;
      wait_sig(2, 1'b1, n1);
      chk("load_lead", 13'h1, 13'(mute && n1 >= LEAD - 2));
      wait_sig(0, 1'b0, n2);
      chk("chg_mute", 13'h1, 13'(n1 + n2 >= HOLD - 2));
      chk("rec_tune", exp, tune);
      chk("rec_band", 13'(bexp), 13'(band));
      $display("Test program change done");
   endtask : t_prog
   task automatic t_search();
      int n;
      logic [12:0] t;
      cyc(1);
      key_lvl <= 2'h2;
      wait_sig(1, 1'b1, n);
      chk("srch_lead", 13'h1, 13'(mute && n >= DEB + LEAD));
      chk("srch_band", 13'h2, 13'(band));
      t = tune;
      cyc(1);
      key_lvl <= 2'h0;
      lock_lvl <= 2'h2;
      cyc(6);
      lock_lvl <= 2'h1;
      cyc(6);
      lock_lvl <= 2'h0;
      cyc(20);
      #1;
      chk("srch_ignore", 13'h1, 13'(srch && tune > t + 13'h2));
      cyc(120);
      lock_lvl <= 2'h2;
      cyc(6);
      lock_lvl <= 2'h1;
      cyc(6);
      lock_lvl <= 2'h0;
      #1;
      t = tune;
      cyc(70);
      #1;
      chk("srch_med", 13'h1, 13'(srch && tune < t));
      cyc(1);
      lock_lvl <= 2'h2;
      wait_sig(1, 1'b0, n);
      t = tune;
      cyc(10 * SUP);
      #1;
      chk("afc_up", 13'h1, 13'(tune - t >= 13'h9 && tune - t <= 13'hB));
      cyc(1);
      lock_lvl <= 2'h0;
      cyc(6);
      #1;
      t = tune;
      cyc(60);
      #1;
      chk("afc_hold", t, tune);
      cyc(1);
      lock_lvl <= 2'h1;
      cyc(3);
      #1;
      t = tune;
      cyc(4 * SDN);
      lock_lvl <= 2'h0;
      #1;
      chk("afc_down", 13'h1, 13'(t - tune >= 13'h3 && t - tune <= 13'h5));
      $display("Test search done");
   endtask : t_search
   task automatic t_restart();
      int n;
      cyc(1);
      key_lvl <= 2'h2;
      wait_sig(1, 1'b1, n);
      cyc(1);
      key_lvl <= 2'h0;
      cyc(10);
      key_lvl <= 2'h1;
      cyc(DEB + LEAD + 10);
      key_lvl <= 2'h0;
      #1;
      chk("new_group", 13'h1, 13'(srch && (band == 4'h1 || band == 4'h8)));
      cyc(1);
      prog_sel <= prog_sel + 4'h1;
      cyc(8);
      #1;
      chk("chg_stop", 13'h0, 13'(srch));
      wait_sig(0, 1'b0, n);
      $display("Test restart done");
   endtask : t_restart
   task automatic t_bounce();
      cyc(1);
      key_lvl <= 2'h2;
      cyc(DEB - 3);
      key_lvl <= 2'h0;
      cyc(2);
      key_lvl <= 2'h2;
      cyc(DEB - 3);
      key_lvl <= 2'h0;
      cyc(LEAD + 10);
      #1;
      chk("bounce", 13'h0, 13'(srch || mute));
      $display("Test bounce done");
   endtask : t_bounce
   task automatic t_store();
      int n;
      cyc(1);
      store_busy <= 1'b1;
      key_lvl <= 2'h2;
      cyc(DEB + 6);
      key_lvl <= 2'h0;
      cyc(LEAD + 10);
      #1;
      chk("store_defer", 13'h0, 13'(srch));
      cyc(1);
      store_busy <= 1'b0;
      wait_sig(1, 1'b1, n);
      cyc(1);
      prog_sel <= prog_sel + 4'h1;
      wait_sig(0, 1'b0, n);
      $display("Test store done");
   endtask : t_store
   initial begin
      t_power();
      t_manual();
      t_prog(1'b0, 13'h0123, 13'h0123, tsa_pkg::BAND_V3, 4'h2);
      t_prog(1'b1, 13'h0100, 13'h00F8, tsa_pkg::BAND_UHF, 4'h4);
      t_search();
      t_restart();
      t_bounce();
      t_store();
      stop_test();
   end
endmodule : tb_tuner_search_afc_control
`default_nettype wire
